// [hdl/psm_consts.vh]
`ifndef PSM_CONSTS_VH
`define PSM_CONSTS_VH

// Register byte offsets on the APB slave.
`define PSM_OFS_SEGMENT_CONTROL_0 12'h000
`define PSM_OFS_SEGMENT_CONTROL_1 12'h004
`define PSM_OFS_SEGMENT_CONTROL_2 12'h008
`define PSM_OFS_BOOTCTL 12'h00C
`define PSM_OFS_BOOTBASE 12'h010
`define PSM_OFS_STATUS 12'h014

// Reset values of the segment control registers (legacy map).
`define PSM_SEGMENT_CONTROL_0_RST 32'h0023_0013
`define PSM_SEGMENT_CONTROL_1_RST 32'h0003_0002
`define PSM_SEGMENT_CONTROL_2_RST 32'h0033_0033
// Implemented bits of a segment control register; the rest read as zero.
`define PSM_SEGCTL_WMASK 32'h0E77_0E77

// Field positions inside one 16-bit segment configuration field.
`define PSM_CCA_LSB 0
`define PSM_MODE_LSB 4
`define PSM_PBASE_LSB 9

// Access-control mode codes.
`define PSM_AM_UNMAPPED_KERNEL_ONLY 3'h0
`define PSM_AM_MAPPED_KERNEL_ONLY 3'h1
`define PSM_AM_MAPPED_KERNEL_SUPERVISOR 3'h2
`define PSM_AM_ALL_LEVELS_MAPPED 3'h3
`define PSM_AM_USER_MAPPED_KERNEL_UNMAPPED 3'h4

// Core supports supervisor mode.
`define PSM_SUP_SUPPORTED 1'b1

// Privilege levels.
`define PSM_PRIV_KERNEL 2'h0
`define PSM_PRIV_SUPERVISOR 2'h1
`define PSM_PRIV_USER 2'h2

// Boot vector: legacy virtual page [31:20] and its physical top bits.
`define PSM_LEGACY_BOOT_VPAGE 12'hBFC
`define PSM_LEGACY_BOOT_PBASE 3'h0
`define PSM_BOOTBASE_RST 12'hBFC
`define PSM_BOOTMASK_RST 8'h00

// Boot control fields.
`define PSM_BOOT_ENH_BIT 0
`define PSM_BOOT_PA_LSB 1
`define PSM_BOOT_MASK_LSB 20

// As-user instruction decode.
`define PSM_LS_LOAD 3'h0
`define PSM_LS_STORE 3'h1
`define PSM_LD_BYTE 3'h0
`define PSM_LD_BYTE_U 3'h1
`define PSM_LD_HALF 3'h2
`define PSM_LD_HALF_U 3'h3
`define PSM_LD_WORD 3'h4
`define PSM_ST_BYTE 3'h0
`define PSM_ST_HALF 3'h1
`define PSM_ST_WORD 3'h2

// Access sizes.
`define PSM_SIZE_BYTE 2'h0
`define PSM_SIZE_HALF 2'h1
`define PSM_SIZE_WORD 2'h2

`endif

// [hdl/psm_segment_map.v]
// Summary of operation
// RULE1: Three segment registers each hold two 16-bit fields, even low, odd high.
// RULE2: Mode at 6:4/22:20; 0x4 user/supervisor mapped kernel unmapped, 0x1 kernel mapped.
// RULE3: Mode 0x2 kernel/supervisor mapped is honoured only if supervisor mode exists.
// RULE4: Under mode 0x4 kernel accesses bypass translation.
// RULE5: Base at 11:9/27:25 gives physical bits 31:29 for untranslated accesses.
// RULE6: Bits 31:28 and 15:12 are unused and read as zero.
// RULE7: Translated kernel segments ignore the base; the TLB supplies the address.
// RULE8: Segments 0-3 are 0.5 GB from the top, segments 4-5 are 1.0 GB at bottom.
// RULE9: Segment 1 may join the unmapped kernel region, its base then used.
// RULE10: Kernel as-user loads and stores get user permissions and translation.
// RULE11: As-user loads byte/half signed or unsigned and word; stores byte/half/word.
// RULE12: Operation type comes from instruction bits 2:0, meaning depends on direction.
// RULE13: Load or store comes from instruction bits 5:3.
// RULE14: Legacy boot vector maps virtual 0xBFC0_0000 to physical 0x1FC0_0000.
// RULE15: Enhanced setting places the boot vector anywhere, mapped anywhere; the code programs only physical bits 31:29, bits 28:20 follow the vector page.
// RULE16: One boot overlay maps the vector to one physical place in either setting.
// RULE17: Boot overlay relocation applies only to kernel-mode accesses.
// RULE18: Cache attribute at 2:0/18:16 applies to untranslated accesses.
// RULE19: The segment is chosen from the upper virtual address bits.
// RULE20: A privilege not allowed by the segment mode raises an address error.
//
// Added by the designer: the address map and register access over APB.
`include "psm_consts.vh"
`default_nettype none

module psm_segment_map (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_rst_n,
  // APB slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [3:0] i_pstrb,
  output reg o_pready,
  output reg [31:0] o_prdata,
  output reg o_pslverr,
  // Address request from the pipeline
  input wire i_req_valid,
  input wire [31:0] i_req_vaddr,
  input wire [1:0] i_req_priv,
  input wire i_req_fetch,
  input wire i_req_as_user,
  input wire [5:0] i_req_instr,
  // Translation result
  output reg o_rsp_valid,
  output reg [31:0] o_rsp_paddr,
  output reg o_rsp_needs_tlb,
  output reg [2:0] o_rsp_cca,
  output reg [2:0] o_rsp_seg,
  output reg o_rsp_addr_err,
  output reg o_rsp_overlay,
  output reg o_rsp_as_user,
  output reg o_rsp_store,
  output reg [1:0] o_rsp_size,
  output reg o_rsp_signed,
  output reg o_rsp_bad_op
);

  reg [31:0] segment_control_0_reg;
  reg [31:0] segment_control_1_reg;
  reg [31:0] segment_control_2_reg;
  reg boot_enh_reg;
  reg [2:0] boot_pa_reg;
  reg [7:0] boot_mask_reg;
  reg [11:0] boot_base_reg;
  reg [31:0] err_count_reg;

  wire apb_setup = i_psel & i_penable & ~o_pready;
  wire apb_done = i_psel & i_penable & o_pready;
  wire wr_done = apb_done & i_pwrite;

  // Byte-lane merge; unimplemented bits never store.
  function [31:0] lane_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] strb;
    input [31:0] wmask;
    integer k;
    begin
      lane_merge = old_val;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          lane_merge[8*k +: 8] = new_val[8*k +: 8];
        end
      end
      lane_merge = lane_merge & wmask;
    end
  endfunction

  // Register write and read decode.
  reg [31:0] rd_data;
  reg rd_hit;
  always @* begin
    rd_hit = 1'b1;
    rd_data = 32'h0000_0000;
    case (i_paddr)
      `PSM_OFS_SEGMENT_CONTROL_0: begin
        rd_data = segment_control_0_reg; // RULE1 RULE6
      end
      `PSM_OFS_SEGMENT_CONTROL_1: begin
        rd_data = segment_control_1_reg;
      end
      `PSM_OFS_SEGMENT_CONTROL_2: begin
        rd_data = segment_control_2_reg;
      end
      `PSM_OFS_BOOTCTL: begin
        rd_data[`PSM_BOOT_ENH_BIT] = boot_enh_reg;
        rd_data[`PSM_BOOT_PA_LSB +: 3] = boot_pa_reg;
        rd_data[`PSM_BOOT_MASK_LSB +: 8] = boot_mask_reg;
      end
      `PSM_OFS_BOOTBASE: begin
        rd_data[31:20] = boot_base_reg;
      end
      `PSM_OFS_STATUS: begin
        rd_data = err_count_reg;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // One wait state: pready is a flop, so the answer comes a cycle into access.
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= apb_setup;
      o_prdata <= (apb_setup & ~i_pwrite & rd_hit) ? rd_data : 32'h0000_0000;
      o_pslverr <= apb_setup & ~rd_hit;
    end
  end

  wire [31:0] boot_wr = lane_merge({4'h0, boot_mask_reg, 16'h0000, boot_pa_reg, boot_enh_reg},
    i_pwdata, i_pstrb, 32'h0FF0_000F);
  // The overlay page sits in the top lanes, so only strobes 3 and 2 can move it.
  wire [31:0] base_wr = lane_merge({boot_base_reg, 20'h0_0000}, i_pwdata, i_pstrb,
    32'hFFF0_0000);

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      segment_control_0_reg <= `PSM_SEGMENT_CONTROL_0_RST;
      segment_control_1_reg <= `PSM_SEGMENT_CONTROL_1_RST;
      segment_control_2_reg <= `PSM_SEGMENT_CONTROL_2_RST;
      boot_enh_reg <= 1'b0;
      boot_pa_reg <= `PSM_LEGACY_BOOT_PBASE;
      boot_mask_reg <= `PSM_BOOTMASK_RST;
      boot_base_reg <= `PSM_BOOTBASE_RST;
    end else if (wr_done) begin
      case (i_paddr)
        `PSM_OFS_SEGMENT_CONTROL_0: begin
          segment_control_0_reg <= lane_merge(segment_control_0_reg, i_pwdata, i_pstrb, `PSM_SEGCTL_WMASK); // RULE6
        end
        `PSM_OFS_SEGMENT_CONTROL_1: begin
          segment_control_1_reg <= lane_merge(segment_control_1_reg, i_pwdata, i_pstrb, `PSM_SEGCTL_WMASK); // RULE6
        end
        `PSM_OFS_SEGMENT_CONTROL_2: begin
          segment_control_2_reg <= lane_merge(segment_control_2_reg, i_pwdata, i_pstrb, `PSM_SEGCTL_WMASK); // RULE6
        end
        `PSM_OFS_BOOTCTL: begin
          boot_enh_reg <= boot_wr[`PSM_BOOT_ENH_BIT];
          boot_pa_reg <= boot_wr[`PSM_BOOT_PA_LSB +: 3];
          boot_mask_reg <= boot_wr[`PSM_BOOT_MASK_LSB +: 8];
        end
        `PSM_OFS_BOOTBASE: begin
          boot_base_reg <= base_wr[31:20];
        end
        default: begin
        end
      endcase
    end
  end

  // Segment select from the top address bits.
  reg [2:0] seg_idx;
  reg [15:0] seg_cfg;
  always @* begin
    case (i_req_vaddr[31:29]) // RULE8 RULE19
      3'h7: seg_idx = 3'h0;
      3'h6: seg_idx = 3'h1;
      3'h5: seg_idx = 3'h2;
      3'h4: seg_idx = 3'h3;
      3'h3, 3'h2: seg_idx = 3'h4;
      default: seg_idx = 3'h5;
    endcase
    case (seg_idx) // RULE1
      3'h0: seg_cfg = segment_control_0_reg[15:0];
      3'h1: seg_cfg = segment_control_0_reg[31:16];
      3'h2: seg_cfg = segment_control_1_reg[15:0];
      3'h3: seg_cfg = segment_control_1_reg[31:16];
      3'h4: seg_cfg = segment_control_2_reg[15:0];
      default: seg_cfg = segment_control_2_reg[31:16];
    endcase
  end

  wire [2:0] seg_mode = seg_cfg[`PSM_MODE_LSB +: 3]; // RULE2
  wire [2:0] seg_cca = seg_cfg[`PSM_CCA_LSB +: 3]; // RULE18
  wire [2:0] seg_pbase = seg_cfg[`PSM_PBASE_LSB +: 3]; // RULE5
  // 1 GB segments keep one more offset bit than 0.5 GB ones.
  wire [29:0] seg_off = seg_idx[2] ? i_req_vaddr[29:0] : {1'b0, i_req_vaddr[28:0]}; // RULE8

  // As-user decode.
  wire [2:0] ls_sel = i_req_instr[5:3]; // RULE13
  wire [2:0] op_type = i_req_instr[2:0]; // RULE12
  reg dec_store;
  reg [1:0] dec_size;
  reg dec_signed;
  reg dec_bad;
  always @* begin
    dec_store = 1'b0;
    dec_size = `PSM_SIZE_WORD;
    dec_signed = 1'b0;
    dec_bad = 1'b0;
    if (ls_sel == `PSM_LS_LOAD) begin
      case (op_type) // RULE11 RULE12
        `PSM_LD_BYTE: begin
          dec_size = `PSM_SIZE_BYTE;
          dec_signed = 1'b1;
        end
        `PSM_LD_BYTE_U: dec_size = `PSM_SIZE_BYTE;
        `PSM_LD_HALF: begin
          dec_size = `PSM_SIZE_HALF;
          dec_signed = 1'b1;
        end
        `PSM_LD_HALF_U: dec_size = `PSM_SIZE_HALF;
        `PSM_LD_WORD: dec_size = `PSM_SIZE_WORD;
        default: dec_bad = 1'b1;
      endcase
    end else if (ls_sel == `PSM_LS_STORE) begin
      dec_store = 1'b1;
      case (op_type) // RULE11 RULE12
        `PSM_ST_BYTE: dec_size = `PSM_SIZE_BYTE;
        `PSM_ST_HALF: dec_size = `PSM_SIZE_HALF;
        `PSM_ST_WORD: dec_size = `PSM_SIZE_WORD;
        default: dec_bad = 1'b1;
      endcase
    end else begin
      dec_bad = 1'b1;
    end
  end

  // As-user accesses are only legal from kernel mode; there they run at user level.
  wire as_user = i_req_as_user & ~i_req_fetch;
  wire as_user_bad = as_user & (dec_bad | (i_req_priv != `PSM_PRIV_KERNEL));
  wire [1:0] eff_priv = as_user ? `PSM_PRIV_USER : i_req_priv; // RULE10
  wire is_kernel = (eff_priv == `PSM_PRIV_KERNEL);
  wire is_super = (eff_priv == `PSM_PRIV_SUPERVISOR);

  // Access mode check: allowed and translated per privilege.
  reg acc_ok;
  reg acc_mapped;
  always @* begin
    acc_ok = 1'b0;
    acc_mapped = 1'b1;
    case (seg_mode)
      `PSM_AM_UNMAPPED_KERNEL_ONLY: begin
        acc_ok = is_kernel;
        acc_mapped = 1'b0;
      end
      `PSM_AM_MAPPED_KERNEL_ONLY: begin
        acc_ok = is_kernel; // RULE2 RULE7
      end
      `PSM_AM_MAPPED_KERNEL_SUPERVISOR: begin
        // Without supervisor mode this behaves as kernel-only.
        acc_ok = is_kernel | (is_super & `PSM_SUP_SUPPORTED); // RULE3
      end
      `PSM_AM_ALL_LEVELS_MAPPED: begin
        acc_ok = 1'b1;
      end
      `PSM_AM_USER_MAPPED_KERNEL_UNMAPPED: begin
        acc_ok = 1'b1;
        acc_mapped = ~is_kernel; // RULE4 RULE9
      end
      default: begin
        acc_ok = 1'b0;
      end
    endcase
  end

  // Boot overlay: one window, legacy page or programmed page, kernel only.
  wire [11:0] ovl_vpage = boot_enh_reg ? boot_base_reg : `PSM_LEGACY_BOOT_VPAGE; // RULE14 RULE15
  wire [2:0] ovl_pbase = boot_enh_reg ? boot_pa_reg : `PSM_LEGACY_BOOT_PBASE; // RULE16
  wire [11:0] ovl_keep = ~{4'h0, boot_mask_reg};
  wire ovl_hit = is_kernel & (((i_req_vaddr[31:20] ^ ovl_vpage) & ovl_keep) == 12'h000); // RULE17
  wire [8:0] ovl_page = (ovl_vpage[8:0] & ovl_keep[8:0]) | (i_req_vaddr[28:20] & ~ovl_keep[8:0]);
  wire [31:0] ovl_paddr = {ovl_pbase, ovl_page, i_req_vaddr[19:0]}; // RULE14 RULE16
  wire [31:0] seg_paddr = {seg_pbase, 29'h0000_0000} + {2'b00, seg_off}; // RULE5

  // The overlay beats the segment checks, so the boot page stays reachable in any map.
  // A malformed as-user access reports as a bad operation, never as an address error.
  wire err_now = i_req_valid & ~as_user_bad & ~ovl_hit & ~acc_ok; // RULE20

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rsp_valid <= 1'b0;
      o_rsp_paddr <= 32'h0000_0000;
      o_rsp_needs_tlb <= 1'b0;
      o_rsp_cca <= 3'h0;
      o_rsp_seg <= 3'h0;
      o_rsp_addr_err <= 1'b0;
      o_rsp_overlay <= 1'b0;
      o_rsp_as_user <= 1'b0;
      o_rsp_store <= 1'b0;
      o_rsp_size <= `PSM_SIZE_WORD;
      o_rsp_signed <= 1'b0;
      o_rsp_bad_op <= 1'b0;
      err_count_reg <= 32'h0000_0000;
    end else begin
      o_rsp_valid <= i_req_valid;
      o_rsp_seg <= seg_idx;
      o_rsp_cca <= seg_cca; // RULE18
      o_rsp_as_user <= i_req_valid & as_user;
      o_rsp_store <= i_req_valid & as_user & dec_store;
      o_rsp_size <= as_user ? dec_size : `PSM_SIZE_WORD;
      o_rsp_signed <= as_user & dec_signed;
      o_rsp_bad_op <= i_req_valid & as_user_bad;
      o_rsp_addr_err <= err_now; // RULE20
      o_rsp_overlay <= i_req_valid & ~as_user_bad & ovl_hit;
      if (ovl_hit) begin
        o_rsp_paddr <= ovl_paddr; // RULE16
        o_rsp_needs_tlb <= 1'b0;
      end else if (acc_mapped) begin
        // The TLB translates; the virtual address is passed on untouched.
        o_rsp_paddr <= i_req_vaddr; // RULE7
        o_rsp_needs_tlb <= i_req_valid & acc_ok & ~as_user_bad;
      end else begin
        o_rsp_paddr <= seg_paddr; // RULE4 RULE5 RULE9
        o_rsp_needs_tlb <= 1'b0;
      end
      // The counter wraps silently; software compares two reads to spot new errors.
      if (err_now) begin
        err_count_reg <= err_count_reg + 32'h0000_0001;
      end
    end
  end

endmodule // psm_segment_map

`default_nettype wire

// [test/psm_pipe_model.sv]
`default_nettype none
module psm_pipe_model (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Request to issue
  input wire logic i_go,
  input wire logic [31:0] i_va,
  input wire logic [1:0] i_priv,
  input wire logic i_fetch,
  input wire logic i_au,
  input wire logic [5:0] i_instr,
  // Pipeline address request
  output logic o_req_valid,
  output logic [31:0] o_req_vaddr,
  output logic [1:0] o_req_priv,
  output logic o_req_fetch,
  output logic o_req_as_user,
  output logic [5:0] o_req_instr
);
  // Idle lines toggle so a design that samples them outside a valid cycle cannot pass by luck.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {o_req_valid, o_req_vaddr, o_req_priv, o_req_fetch, o_req_as_user, o_req_instr} <= '0;
    end else if (i_go) begin
      {o_req_valid, o_req_vaddr, o_req_priv} <= {1'b1, i_va, i_priv};
      {o_req_fetch, o_req_as_user, o_req_instr} <= {i_fetch, i_au, i_instr};
    end else begin
      {o_req_valid, o_req_vaddr, o_req_priv} <= {1'b0, ~o_req_vaddr, ~o_req_priv};
      {o_req_fetch, o_req_as_user, o_req_instr} <= ~{o_req_fetch, o_req_as_user, o_req_instr};
    end
  end
endmodule // psm_pipe_model
`default_nettype wire

// [test/psm_segment_map_checker.sv]
`default_nettype none
module psm_segment_map_checker (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Register bus
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  // Request and result
  input wire logic i_req_valid,
  input wire logic [31:0] i_req_vaddr,
  input wire logic [1:0] i_req_priv,
  input wire logic i_req_fetch,
  input wire logic i_req_as_user,
  input wire logic [5:0] i_req_instr,
  input wire logic o_rsp_valid,
  input wire logic [31:0] o_rsp_paddr,
  input wire logic o_rsp_needs_tlb,
  input wire logic [2:0] o_rsp_seg,
  input wire logic o_rsp_addr_err,
  input wire logic o_rsp_overlay,
  input wire logic o_rsp_as_user,
  input wire logic o_rsp_store,
  input wire logic o_rsp_bad_op
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  function automatic logic [2:0] seg_of(input logic [2:0] t);
    seg_of = t[2] ? 3'h7 - t : (t[1] ? 3'h4 : 3'h5);
  endfunction
  sequence apb_setup;
    i_psel && !i_penable;
  endsequence
  sequence one_wait;
    !o_pready ##1 o_pready;
  endsequence
  a_apb_wait: assert property (
    apb_setup |=> one_wait) else $error("register answer not after one wait state");
  a_ready_in_access: assert property (
    o_pready |-> i_psel && i_penable) else $error("ready outside an access phase");
  a_rsp_follows: assert property (
    i_req_valid |=> o_rsp_valid) else $error("request not answered next cycle");
  a_no_stray_rsp: assert property (
    !i_req_valid |=> !o_rsp_valid) else $error("answer without a request");
  a_seg_decode: assert property (
    i_req_valid |=> o_rsp_seg == seg_of($past(i_req_vaddr[31:29])))
    else $error("wrong segment chosen");
  a_tlb_keeps_va: assert property (
    i_req_valid ##1 o_rsp_needs_tlb |-> o_rsp_paddr == $past(i_req_vaddr))
    else $error("translated access does not pass the virtual address");
  a_err_no_tlb: assert property (
    o_rsp_valid && o_rsp_addr_err |-> !o_rsp_needs_tlb) else $error("refused access sent on");
  a_bad_op_quiet: assert property (
    o_rsp_valid && o_rsp_bad_op |-> !o_rsp_addr_err && !o_rsp_overlay && !o_rsp_needs_tlb)
    else $error("bad operation not suppressed");
  a_store_decode: assert property (
    i_req_valid && i_req_as_user && !i_req_fetch && i_req_priv == 2'h0
    && i_req_instr[5:3] == 3'h1 && i_req_instr[2:0] < 3'h3
    |=> o_rsp_store && o_rsp_as_user && !o_rsp_bad_op) else $error("store not decoded");
  a_overlay_kernel: assert property (
    o_rsp_valid && o_rsp_overlay |-> $past(i_req_priv) == 2'h0)
    else $error("overlay hit outside kernel mode");
endmodule // psm_segment_map_checker
bind psm_segment_map psm_segment_map_checker chk (.i_ref_clk, .i_rst_n, .i_psel, .i_penable,
  .o_pready, .i_req_valid, .i_req_vaddr, .i_req_priv, .i_req_fetch, .i_req_as_user,
  .i_req_instr, .o_rsp_valid, .o_rsp_paddr, .o_rsp_needs_tlb, .o_rsp_seg, .o_rsp_addr_err,
  .o_rsp_overlay, .o_rsp_as_user, .o_rsp_store, .o_rsp_bad_op);
`default_nettype wire

// [test/testbench.sv]
`include "psm_consts.vh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_ref_clk = 1'b0, i_rst_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0000_0000, va = 32'h0000_0000, rd, sc [3];
  logic [3:0] i_pstrb = 4'hF;
  logic go = 1'b0, fch = 1'b0, au = 1'b0, er;
  logic [1:0] pv = 2'h0;
  logic [5:0] ins = 6'h00;
  wire logic i_req_valid, i_req_fetch, i_req_as_user, o_pready, o_pslverr, o_rsp_valid;
  wire logic o_rsp_needs_tlb, o_rsp_addr_err, o_rsp_overlay, o_rsp_as_user, o_rsp_store;
  wire logic o_rsp_signed, o_rsp_bad_op;
  wire logic [31:0] i_req_vaddr, o_prdata, o_rsp_paddr;
  wire logic [1:0] i_req_priv, o_rsp_size;
  wire logic [5:0] i_req_instr;
  wire logic [2:0] o_rsp_cca, o_rsp_seg;
  int miscompares = 0, checks = 0;
  psm_pipe_model pipe (.i_ref_clk, .i_rst_n, .i_go(go), .i_va(va), .i_priv(pv), .i_fetch(fch),
    .i_au(au), .i_instr(ins), .o_req_valid(i_req_valid), .o_req_vaddr(i_req_vaddr),
    .o_req_priv(i_req_priv), .o_req_fetch(i_req_fetch), .o_req_as_user(i_req_as_user),
    .o_req_instr(i_req_instr));
  psm_segment_map dut (.i_ref_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .i_pstrb, .o_pready, .o_prdata, .o_pslverr, .i_req_valid, .i_req_vaddr,
    .i_req_priv, .i_req_fetch, .i_req_as_user, .i_req_instr, .o_rsp_valid, .o_rsp_paddr,
    .o_rsp_needs_tlb, .o_rsp_cca, .o_rsp_seg, .o_rsp_addr_err, .o_rsp_overlay,
    .o_rsp_as_user, .o_rsp_store, .o_rsp_size, .o_rsp_signed, .o_rsp_bad_op);
  initial begin
    forever #20 i_ref_clk = ~i_ref_clk;
  end
  task automatic finish_test();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, d};
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    rd = o_prdata;
    er = o_pslverr;
    {i_psel, i_penable} <= 2'b00;
    // One idle edge keeps the next setup from assigning psel in this same time step.
    @(posedge i_ref_clk);
    if (n >= 20) chk(32'h0, 32'h1);
  endtask
  task automatic req(input logic [31:0] a, input logic [1:0] p, input logic u,
      input logic [5:0] c);
    {va, pv, au, ins, go} <= {a, p, u, c, 1'b1};
    fch <= !u && $urandom_range(1) == 1;
    @(posedge i_ref_clk);
    go <= 1'b0;
    @(posedge i_ref_clk);
    // Results launched at the previous edge still stand until this edge updates them.
    @(posedge i_ref_clk);
    chk(o_rsp_valid, 1'b1);
  endtask
  // Mirror of the legacy-overlay and segment decision for a plain access.
  function automatic void exp_map(input logic [31:0] a, input logic [1:0] p, output logic e,
      output logic t, output logic o, output logic [2:0] c, output logic [2:0] s,
      output logic [31:0] pa);
    logic [15:0] f;
    logic [2:0] m;
    logic ok, mp;
    s = a[31] ? 3'h7 - a[31:29] : (a[30] ? 3'h4 : 3'h5);
    f = s[0] ? sc[s[2:1]][31:16] : sc[s[2:1]][15:0];
    m = f[6:4];
    c = f[2:0];
    ok = m < 3'h2 ? p == 2'h0 : m == 3'h2 ? p != 2'h2 : m < 3'h5;
    mp = m == 3'h4 ? p != 2'h0 : m != 3'h0;
    o = p == 2'h0 && a[31:20] == 12'hBFC;
    e = !ok && !o;
    t = ok && mp && !o;
    pa = o ? {12'h1FC, a[19:0]} : mp ? a : {f[11:9], 29'h0} + (s[2] ? a[29:0] : a[28:0]);
  endfunction
  task automatic map_chk(input logic [31:0] a, input logic [1:0] p);
    logic e, t, o;
    logic [2:0] c, s;
    logic [31:0] pa;
    req(a, p, 1'b0, 6'h00);
    exp_map(a, p, e, t, o, c, s, pa);
    chk(o_rsp_seg, s);
    chk(o_rsp_addr_err, e);
    chk(o_rsp_needs_tlb, t);
    chk(o_rsp_overlay, o);
    if (!o) chk(o_rsp_cca, c);
    if (!e) chk(o_rsp_paddr, pa);
  endtask
  initial begin
    #800us;
    miscompares++;
    finish_test();
  end
  initial begin
    logic ld, bad;
    logic [31:0] wd;
    void'($urandom(32'hb45e));
    sc = '{`PSM_SEGMENT_CONTROL_0_RST, `PSM_SEGMENT_CONTROL_1_RST, `PSM_SEGMENT_CONTROL_2_RST};
    repeat (3) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    @(posedge i_ref_clk);
    for (int k = 0; k < 3; k++) begin
      apb(1'b0, 12'(k * 4), 32'h0);
      chk(rd, sc[k]);
    end
    apb(1'b0, 12'h018, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    $display("test reset values done");
    for (int c = 0; c < 64; c++) begin
      // As-user from kernel to a user-mapped segment; table of all instruction codes.
      req(32'h4000_0100, 2'h0, 1'b1, c[5:0]);
      ld = c[5:3] == 3'h0;
      bad = ld ? c[2:0] > 3'h4 : c[5:3] != 3'h1 || c[2:0] > 3'h2;
      chk(o_rsp_bad_op, bad);
      chk(o_rsp_needs_tlb, !bad);
      if (!bad) chk(o_rsp_store, !ld);
      if (!bad) chk(o_rsp_size, ld ? (c[2] ? 2'h2 : {1'b0, c[1]}) : c[1:0]);
      if (!bad) chk(o_rsp_signed, ld && !c[2] && !c[0]);
    end
    req(32'hBFC0_0000, 2'h0, 1'b1, 6'h04);
    chk({o_rsp_addr_err, o_rsp_overlay}, 2'b10);
    req(32'h4000_0100, 2'h2, 1'b1, 6'h04);
    chk({o_rsp_bad_op, o_rsp_needs_tlb}, 2'b10);
    $display("test as-user done");
    map_chk(32'hBFC0_0010, 2'h0);
    map_chk(32'hBFC0_0010, 2'h2);
    apb(1'b1, `PSM_OFS_BOOTCTL, 32'h0000_000B);
    apb(1'b1, `PSM_OFS_BOOTBASE, 32'h1230_0000);
    apb(1'b0, `PSM_OFS_BOOTCTL, 32'h0000_0000);
    chk(rd, 32'h0000_000B);
    req(32'h1230_0040, 2'h0, 1'b0, 6'h00);
    chk({o_rsp_overlay, o_rsp_paddr}, {1'b1, 32'hB230_0040});
    req(32'hBFC0_0010, 2'h0, 1'b0, 6'h00);
    chk(o_rsp_overlay, 1'b0);
    apb(1'b1, `PSM_OFS_BOOTCTL, 32'h0000_0000);
    apb(1'b1, `PSM_OFS_BOOTBASE, 32'hBFC0_0000);
    $display("test boot overlay done");
    sc[0] = 32'h0C43_0013;
    apb(1'b1, `PSM_OFS_SEGMENT_CONTROL_0, sc[0]);
    map_chk(32'hC000_1234, 2'h0);
    map_chk(32'hC000_1234, 2'h2);
    $display("test extended region done");
    for (int i = 0; i < 12; i++) begin
      for (int k = 0; k < 3; k++) begin
        wd = $urandom;
        sc[k] = wd & `PSM_SEGCTL_WMASK;
        apb(1'b1, 12'(k * 4), wd);
        apb(1'b0, 12'(k * 4), 32'h0);
        chk(rd, sc[k]);
      end
      for (int j = 0; j < 20; j++) map_chk($urandom, 2'($urandom_range(2)));
    end
    $display("test random map done");
    finish_test();
  end
endmodule // testbench
`default_nettype wire
